// ---- rtl/low_power_mode_control.sv ----
module low_power_mode_control
  import lpm_pkg::*;
#(
  parameter power_option_t POWER_OPTION = PWR_LI
)
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // core side
  input wire core_req_t coreReq,
  input wire logic [HRF_COUNT:1] haltWakeEnable,
  input wire logic [HRF_COUNT:1] haltReleaseEvent,
  input wire logic portCChangeEn,
  input wire logic portDChangeEn,
  input wire logic portCFiltered,
  input wire logic portDFiltered,
  // wake pins
  input wire wake_pins_t wakePins,
  // status outputs
  output logic [2:0] stopWakeEnable,
  output logic [HRF_COUNT:0] haltReleaseFlag,
  output logic portCChangeFlag,
  output logic portDChangeFlag,
  output logic heavyLoadFlag,
  output logic fetchEnable,
  output logic oscStopped,
  output logic extraOscBuffer,
  output logic internalSupplyRail
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    wake_pins_t sync1;
    wake_pins_t sync2;
    wake_pins_t prev;
    logic [2:0] swe;
    logic portDWake;
    logic [HRF_COUNT:0] halt_release_flag;
    logic scfC;
    logic scfD;
    logic heavy;
    mode_t mode;
    logic inService;
    logic fetch;
    logic oscOff;
    logic extraBuf;
    logic rail;
    logic stopped;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic keyChange;
  logic extChange;
  logic portCHigh;
  logic portDHigh;
  logic stopRelease;
  logic haltRelease;
  logic [HRF_COUNT:0] setFlags;

  always_comb
  begin
    next_cur = cur;
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    next_cur.sync1 = wakePins;
    next_cur.sync2 = cur.sync1;
    next_cur.prev = cur.sync2;

    keyChange = |(cur.sync2.keyInputs ^ cur.prev.keyInputs);
    extChange = cur.sync2.extPin ^ cur.prev.extPin;
    portCHigh = |cur.sync2.portC;
    portDHigh = |cur.sync2.portD;

    // ---------------------------------------------------------------
    // stop-wake enable register
    // ---------------------------------------------------------------
    if (coreReq.stopWakeEnableInstr)
    begin
      next_cur.swe[SW_KEY] = coreReq.operand[SWE_KEY_BIT];
      next_cur.swe[SW_EXT] = coreReq.operand[SWE_EXT_BIT];
      next_cur.swe[SW_PORT] = coreReq.operand[SWE_PORTC_BIT];
      next_cur.portDWake = coreReq.operand[SWE_PORTD_BIT];
    end

    // ---------------------------------------------------------------
    // release flags; set wins over clear
    // ---------------------------------------------------------------
    setFlags = '0;
    setFlags[HRF_COUNT:1] = haltReleaseEvent;
    if (extChange)
      setFlags[HRF_EXT] = 1'b1;
    if (keyChange)
      setFlags[HRF_KEY] = 1'b1;
    if (coreReq.flagClearInstr)
      next_cur.halt_release_flag = cur.halt_release_flag & ~coreReq.clearMask;
    if (coreReq.interruptAccept)
      next_cur.halt_release_flag = next_cur.halt_release_flag & ~coreReq.acceptedFlag;
    if (coreReq.flagClearInstr && coreReq.clearMask[0])
    begin
      next_cur.scfC = 1'b0;
      next_cur.scfD = 1'b0;
    end
    if (portCChangeEn && portCFiltered)
      next_cur.scfC = 1'b1;
    if (portDChangeEn && portDFiltered)
      next_cur.scfD = 1'b1;
    setFlags[0] = next_cur.scfC | next_cur.scfD;
    next_cur.halt_release_flag = next_cur.halt_release_flag | setFlags;

    haltRelease = cur.scfC | cur.scfD | (|(cur.halt_release_flag[HRF_COUNT:1] & haltWakeEnable));
    stopRelease = (cur.swe[SW_KEY] & haltWakeEnable[HRF_KEY] & keyChange)
      | (cur.swe[SW_EXT] & haltWakeEnable[HRF_EXT] & extChange)
      | (cur.swe[SW_PORT] & portCChangeEn & portCHigh)
      | (cur.portDWake & portDChangeEn & portDHigh);

    // ---------------------------------------------------------------
    // mode sequencing
    // ---------------------------------------------------------------
    next_cur.inService = cur.inService;
    unique case (cur.mode)
      MODE_RUN:
      begin
        if (coreReq.haltInstr && !(haltRelease || (|cur.halt_release_flag)))
          next_cur.mode = MODE_HALT;
        else if (coreReq.stopInstr)
        begin
          next_cur.heavy = 1'b1;
          next_cur.mode = stopRelease ? MODE_HALT : MODE_STOP;
        end
        else if (coreReq.returnInstr && cur.inService)
        begin
          next_cur.inService = 1'b0;
          next_cur.mode = MODE_HALT;
        end
      end
      MODE_HALT:
      begin
        if (coreReq.interruptAccept)
        begin
          next_cur.inService = 1'b1;
          next_cur.mode = MODE_RUN;
        end
        else if (haltRelease)
          next_cur.mode = MODE_RUN;
        else if (cur.oscOff && !portCHigh && !portDHigh && !cur.scfC && !cur.scfD)
          next_cur.mode = MODE_STOP;
      end
      MODE_STOP:
      begin
        next_cur.heavy = 1'b1;
        if (stopRelease)
          next_cur.mode = MODE_HALT;
      end
    endcase
    if (next_cur.mode == MODE_HALT && cur.mode == MODE_STOP)
      next_cur.oscOff = 1'b1;
    else if (next_cur.mode != MODE_HALT)
      next_cur.oscOff = 1'b0;

    // ---------------------------------------------------------------
    // heavy-load flag
    // ---------------------------------------------------------------
    if (cur.mode != MODE_STOP && coreReq.flagSel == FLAG_HEAVY_LOAD)
    begin
      if (coreReq.setFlagInstr)
        next_cur.heavy = 1'b1;
      else if (coreReq.clearFlagInstr)
        next_cur.heavy = 1'b0;
    end
    if (next_cur.mode == MODE_STOP)
      next_cur.heavy = 1'b1;

    next_cur.fetch = (next_cur.mode == MODE_RUN);
    // registered stop indication, so the pin comes straight from a flop
    next_cur.stopped = (next_cur.mode == MODE_STOP);
    next_cur.extraBuf = next_cur.heavy | (POWER_OPTION == PWR_EXTV);
    if (POWER_OPTION == PWR_LI)
      next_cur.rail = next_cur.heavy;
    else
      next_cur.rail = (POWER_OPTION == PWR_EXTV);

    if (srst)
    begin
      next_cur = '0;
      next_cur.swe = SW_RESET;
      next_cur.mode = MODE_RUN;
      next_cur.fetch = 1'b1;
      if (POWER_OPTION == PWR_EXTV)
      begin
        next_cur.heavy = HEAVY_RESET_EXTV;
        next_cur.extraBuf = 1'b1;
        next_cur.rail = 1'b1;
      end
      else
      begin
        next_cur.heavy = HEAVY_RESET_AGLI;
        next_cur.extraBuf = 1'b1;
        next_cur.rail = (POWER_OPTION == PWR_LI);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    cur <= next_cur;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign stopWakeEnable = cur.swe;
  assign haltReleaseFlag = cur.halt_release_flag;
  assign portCChangeFlag = cur.scfC;
  assign portDChangeFlag = cur.scfD;
  assign heavyLoadFlag = cur.heavy;
  assign fetchEnable = cur.fetch;
  assign oscStopped = cur.stopped;
  assign extraOscBuffer = cur.extraBuf;
  assign internalSupplyRail = cur.rail;

endmodule // low_power_mode_control

// ---- rtl/lpm_pkg.sv ----
package lpm_pkg;

  // ---------------------------------------------------------------
  // power options
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_AG,
    PWR_LI,
    PWR_EXTV
  } power_option_t;

  // ---------------------------------------------------------------
  // operand layout of the stop-wake enable instruction
  // ---------------------------------------------------------------
  localparam int SWE_KEY_BIT = 7;
  localparam int SWE_EXT_BIT = 5;
  localparam int SWE_PORTC_BIT = 4;
  localparam int SWE_PORTD_BIT = 3;
  localparam logic [7:0] SWE_ALL_OPERAND = 8'hb0;

  // stored register bit positions
  localparam int SW_KEY = 2;
  localparam int SW_EXT = 1;
  localparam int SW_PORT = 0;
  localparam logic [2:0] SW_RESET = 3'h0;

  // operand of set/clear flag selecting the heavy-load flag
  localparam logic [3:0] FLAG_HEAVY_LOAD = 4'h2;

  // halt-release flag indices 1..6
  localparam int HRF_EXT = 2;
  localparam int HRF_KEY = 5;
  localparam int HRF_COUNT = 6;

  localparam logic HEAVY_RESET_AGLI = 1'b1;
  localparam logic HEAVY_RESET_EXTV = 1'b0;

  // ---------------------------------------------------------------
  // mode states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_HALT,
    MODE_STOP
  } mode_t;

  // core instruction strobes
  typedef struct packed {
    logic stopWakeEnableInstr;
    logic [7:0] operand;
    logic haltInstr;
    logic stopInstr;
    logic returnInstr;
    logic interruptAccept;
    logic [HRF_COUNT:0] acceptedFlag;
    logic flagClearInstr;
    logic [HRF_COUNT:0] clearMask;
    logic setFlagInstr;
    logic clearFlagInstr;
    logic [3:0] flagSel;
  } core_req_t;

  // synchronised wake pins
  typedef struct packed {
    logic [3:0] keyInputs;
    logic [3:0] portC;
    logic [3:0] portD;
    logic extPin;
  } wake_pins_t;

endpackage

// ---- dv/lpm_monitor.sv ----
module lpm_monitor
  import lpm_pkg::*;
#(
  parameter power_option_t POWER_OPTION = PWR_LI
)
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // watched ports
  input wire core_req_t coreReq,
  input wire logic [2:0] stopWakeEnable,
  input wire logic [HRF_COUNT:0] haltReleaseFlag,
  input wire logic heavyLoadFlag,
  input wire logic fetchEnable,
  input wire logic oscStopped,
  input wire logic internalSupplyRail
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] sweOp;
  always_ff @(posedge clk) sweOp <= {coreReq.operand[7], coreReq.operand[5], coreReq.operand[4]};
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // -----------
  // checks
  // -----------
  a_swe_reset_zero: assert property ($fell(srst) |-> stopWakeEnable == 3'h0)
    else $error("stop-wake enable not zero after reset");
  a_swe_write_map: assert property (coreReq.stopWakeEnableInstr |=> stopWakeEnable == sweOp)
    else $error("stop-wake enable bits misplaced");
  a_swe_only_instr: assert property (!coreReq.stopWakeEnableInstr |=> $stable(stopWakeEnable))
    else $error("stop-wake enable changed without instruction");
  a_stop_forces_heavy: assert property (oscStopped |-> heavyLoadFlag)
    else $error("heavy-load low in stop");
  a_heavy_set_op: assert property (coreReq.setFlagInstr && coreReq.flagSel == 4'h2 |=> heavyLoadFlag)
    else $error("set-flag did not set heavy-load");
  a_heavy_clear_op: assert property (coreReq.clearFlagInstr && coreReq.flagSel == 4'h2 && !oscStopped
    && !coreReq.setFlagInstr && !coreReq.stopInstr |=> !heavyLoadFlag)
    else $error("clear-flag did not clear heavy-load");
  a_li_rail_track: assert property (POWER_OPTION == PWR_LI && $stable(heavyLoadFlag)
    |-> internalSupplyRail == heavyLoadFlag)
    else $error("supply rail does not follow heavy-load");
  a_halt_refused: assert property (coreReq.haltInstr && (|haltReleaseFlag) && fetchEnable
    |=> fetchEnable [*2])
    else $error("halt entered with release pending");
endmodule // lpm_monitor

bind low_power_mode_control lpm_monitor #(.POWER_OPTION(POWER_OPTION)) mon (
  .clk, .srst, .coreReq, .stopWakeEnable, .haltReleaseFlag,
  .heavyLoadFlag, .fetchEnable, .oscStopped, .internalSupplyRail);

// ---- dv/wake_source.sv ----
module wake_source
  import lpm_pkg::*;
(
  // clock
  input wire logic clk,
  // requested pin levels
  input wire logic [12:0] levels,
  // pins
  output wake_pins_t wakePins
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins move off the clock edge, as a real pin would
  initial wakePins = '0;
  always @(posedge clk) wakePins <= #3 levels;
endmodule // wake_source

// ---- dv/tb.sv ----
module tb;
  import lpm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SWE = 0, HALT = 1, STOP = 2, ACC = 3, FCLR = 4, SETF = 5, CLRF = 6, RET = 7;
  logic portCFiltered;
  logic portCChangeFlag;
  logic clk;
  logic srst;
  core_req_t coreReq;
  logic [HRF_COUNT:1] haltWakeEnable;
  logic [HRF_COUNT:1] haltReleaseEvent;
  logic [12:0] levels;
  wake_pins_t wakePins;
  logic [2:0] stopWakeEnable;
  logic [HRF_COUNT:0] haltReleaseFlag;
  logic heavyLoadFlag, fetchEnable, oscStopped, extraOscBuffer, internalSupplyRail;
  int error_cnt = 0;
  int tests_run = 0;
  wake_source src (.clk, .levels, .wakePins);
  low_power_mode_control #(.POWER_OPTION(PWR_LI)) dut (
    .clk, .srst, .coreReq, .haltWakeEnable, .haltReleaseEvent,
    .portCChangeEn(1'b1), .portDChangeEn(1'b0), .portCFiltered, .portDFiltered(1'b0),
    .wakePins, .stopWakeEnable, .haltReleaseFlag, .portCChangeFlag, .portDChangeFlag(),
    .heavyLoadFlag, .fetchEnable, .oscStopped, .extraOscBuffer, .internalSupplyRail);
  // -----------
  // helpers
  // -----------
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task op(input int k, input logic [7:0] v);
    core_req_t r;
    r = '0;
    r.operand = v;
    r.flagSel = v[3:0];
    r.clearMask = v[6:0];
    r.acceptedFlag = v[6:0];
    case (k)
      SWE: r.stopWakeEnableInstr = 1'b1;
      HALT: r.haltInstr = 1'b1;
      STOP: r.stopInstr = 1'b1;
      ACC: r.interruptAccept = 1'b1;
      FCLR: r.flagClearInstr = 1'b1;
      SETF: r.setFlagInstr = 1'b1;
      RET: r.returnInstr = 1'b1;
      default: r.clearFlagInstr = 1'b1;
    endcase
    @(posedge clk) coreReq <= r;
    @(posedge clk) coreReq <= '0;
    #1;
  endtask
  task fire(input logic [HRF_COUNT:1] v);
    @(posedge clk) haltReleaseEvent <= v;
    @(posedge clk) haltReleaseEvent <= '0;
    #1;
  endtask
  task settle;
    for (int i = 0; i < 20 && fetchEnable !== 1'b1; i++) @(posedge clk);
    #1;
  endtask
  // -----------
  // scenarios
  // -----------
  task t_reset;
    chk("stopWakeEnable", 8'h00, stopWakeEnable);
    chk("heavyLoadFlag", 8'h01, heavyLoadFlag);
    chk("fetchEnable", 8'h01, fetchEnable);
    $display("test reset done");
  endtask
  task t_swe;
    for (int i = 0; i < 3; i++)
    begin
      op(SWE, 8'h80 >> (i == 0 ? 0 : i + 1));
      chk("stopWakeEnable", 8'h04 >> i, stopWakeEnable);
    end
    op(SWE, 8'hb0);
    chk("stopWakeEnable", 8'h07, stopWakeEnable);
    $display("test stop-wake enable done");
  endtask
  task t_heavy;
    op(CLRF, 8'h03);
    chk("heavyLoadFlag", 8'h01, heavyLoadFlag);
    op(CLRF, 8'h02);
    chk("heavyLoadFlag", 8'h00, heavyLoadFlag);
    @(posedge clk) #1;
    chk("extraOscBuffer", 8'h00, extraOscBuffer);
    chk("internalSupplyRail", 8'h00, internalSupplyRail);
    op(SETF, 8'h02);
    @(posedge clk) #1;
    chk("internalSupplyRail", 8'h01, internalSupplyRail);
    $display("test heavy-load done");
  endtask
  task t_halt;
    @(posedge clk) haltWakeEnable <= 6'h04;
    fire(6'h01);
    chk("haltReleaseFlag", 8'h02, haltReleaseFlag);
    op(HALT, 8'h00);
    chk("fetchEnable", 8'h01, fetchEnable);
    op(FCLR, 8'h02);
    chk("haltReleaseFlag", 8'h00, haltReleaseFlag);
    op(HALT, 8'h00);
    chk("fetchEnable", 8'h00, fetchEnable);
    fire(6'h04);
    settle;
    chk("fetchEnable", 8'h01, fetchEnable);
    op(FCLR, 8'h7f);
    $display("test halt done");
  endtask
  task t_stop;
    @(posedge clk) haltWakeEnable <= 6'h10;
    op(CLRF, 8'h02);
    op(STOP, 8'h00);
    chk("oscStopped", 8'h01, oscStopped);
    chk("heavyLoadFlag", 8'h01, heavyLoadFlag);
    @(posedge clk) levels <= 13'h0200;
    settle;
    chk("oscStopped", 8'h00, oscStopped);
    chk("keyReleaseFlag", 8'h01, haltReleaseFlag[HRF_KEY]);
    op(ACC, 8'h20);
    chk("keyReleaseFlag", 8'h00, haltReleaseFlag[HRF_KEY]);
    chk("fetchEnable", 8'h01, fetchEnable);
    $display("test stop done");
  endtask
  task t_port;
    op(HALT, 8'h00);
    chk("fetchEnable", 8'h00, fetchEnable);
    op(ACC, 8'h00);
    chk("fetchEnable", 8'h01, fetchEnable);
    op(RET, 8'h00);
    chk("fetchEnable", 8'h00, fetchEnable);
    @(posedge clk) portCFiltered <= 1'b1;
    @(posedge clk) portCFiltered <= 1'b0;
    #1;
    chk("portCChangeFlag", 8'h01, portCChangeFlag);
    settle;
    chk("fetchEnable", 8'h01, fetchEnable);
    op(FCLR, 8'h01);
    chk("portCChangeFlag", 8'h00, portCChangeFlag);
    $display("test port change done");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #20us;
    error_cnt++;
    summarize;
  end
  initial
  begin
    srst = 1'b1;
    coreReq = '0;
    haltWakeEnable = '0;
    haltReleaseEvent = '0;
    levels = '0;
    portCFiltered = 1'b0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk) #1;
    t_reset;
    t_swe;
    t_heavy;
    t_halt;
    t_stop;
    t_port;
    summarize;
  end
endmodule // tb
